// file: shared/mss_pkg.sv
// shared constants for the management summary status register
`default_nettype none

package mss_pkg;

  // register bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int NUM_PORTS = 16;

  // offset of the summary status word on the internal register bus
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 20'h1D280;

  // field positions inside the status word
  localparam int POS_RESET_EVENT = 0;
  localparam int POS_SOFT_FLAG_TWO = 1;
  localparam int POS_SOFT_FLAG_ONE = 2;
  localparam int POS_SOFT_FLAG_ZERO = 3;
  localparam int POS_OUTBOUND_MAILBOX_WRITTEN = 4;
  localparam int POS_INBOUND_MAILBOX_READ = 5;
  localparam int POS_MGMT_IRQ = 6;
  localparam int POS_FABRIC_TRANSFER_ERROR = 7;
  localparam int POS_RESET_SYMBOL_EVENT = 8;
  localparam int POS_MULTICAST_SYMBOL_EVENT = 9;
  localparam int POS_LOGICAL_ERROR = 13;
  localparam int POS_MULTICAST_LATENCY_TIMEOUT = 14;
  localparam int POS_MULTICAST_PACKET_DROPPED = 15;
  localparam int POS_PORT_BASE = 16;

  // which bits hold storage, and which software may write
  localparam logic [DATA_W-1:0] IMPL_MASK = 32'hFFFF_E3FF;
  localparam logic [DATA_W-1:0] SOFT_MASK = 32'h0000_000E;

  // reset values: printed value, plus the hardware-reset mark
  localparam logic [DATA_W-1:0] STAT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STAT_HW_RESET = 32'h0000_0001;
  localparam logic ALERT_RESET = 1'b0;

endpackage : mss_pkg

`default_nettype wire

// file: core/mss_sticky_bit.sv
// one status bit: sticky set, write-one-to-clear, optional load
`timescale 1ns/10ps
`default_nettype none

module mss_sticky_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // controls
  input wire logic soft_clr,
  input wire logic set,
  input wire logic clr,
  input wire logic load,
  input wire logic load_val,
  // state
  output logic q
);

  logic next_q; // value for the next edge

  // soft reset first, then software load, then set over clear
  always_comb begin
    if (soft_clr) begin
      next_q = 1'b0;
    end else if (load) begin
      next_q = load_val;
    end else begin
      next_q = set | (q & ~clr);
    end
  end

  // storage, frozen while ce is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VAL;
    end else if (ce) begin
      q <= next_q;
    end
  end

endmodule : mss_sticky_bit

`default_nettype wire

// file: core/mss_alert_detect.sv
// alert flag raised by enabled status bits rising
`timescale 1ns/10ps
`default_nettype none

module mss_alert_detect (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // status and enables
  input wire logic [mss_pkg::DATA_W-1:0] status,
  input wire logic [mss_pkg::DATA_W-1:0] alert_enable,
  input wire logic alert_ack,
  // flag
  output logic alert_flag
);

  logic [mss_pkg::DATA_W-1:0] masked; // enabled status bits
  logic [mss_pkg::DATA_W-1:0] masked_q; // last cycle's view
  logic [mss_pkg::DATA_W-1:0] next_masked_q;
  logic next_alert_flag;
  logic rise; // any enabled bit went 0 to 1

  // an enable rising over a set bit counts as a rise too
  always_comb begin
    masked = status & alert_enable;
    rise = |(masked & ~masked_q);
    next_masked_q = masked;
    // rise wins over acknowledge; drops when nothing is enabled and set
    next_alert_flag = rise | (alert_flag & ~alert_ack & (|masked));
  end

  // registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      masked_q <= '0;
      alert_flag <= mss_pkg::ALERT_RESET;
    end else if (ce) begin
      masked_q <= next_masked_q;
      alert_flag <= next_alert_flag;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_alert_rise;
    ce && (|(status & alert_enable & ~masked_q)) |=> alert_flag;
  endproperty
  a_alert_rise: assert property (p_alert_rise)
    else $error("alert flag missed an enabled rise");

  c_alert: cover property (ce && rise ##1 alert_flag);

endmodule : mss_alert_detect

`default_nettype wire

// file: core/mss_status_reg.sv
// summary status register of the management slave
`timescale 1ns/10ps
`default_nettype none

module mss_status_reg (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // management logic soft reset
  input wire logic mgmt_soft_rst,
  // internal register bus
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [mss_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mss_pkg::DATA_W-1:0] reg_wdata,
  output logic [mss_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // serial management slave side
  input wire logic mgmt_w1c_en,
  input wire logic [mss_pkg::DATA_W-1:0] mgmt_w1c_data,
  output logic [mss_pkg::DATA_W-1:0] mgmt_status,
  // mailbox events
  input wire logic outbound_mailbox_write,
  input wire logic inbound_mailbox_rd,
  input wire logic inbound_mailbox_full,
  // device event sources
  input wire logic mgmt_irq,
  input wire logic [mss_pkg::NUM_PORTS-1:0] fabric_transfer_error,
  input wire logic [mss_pkg::NUM_PORTS-1:0] reset_symbol_event,
  input wire logic [mss_pkg::NUM_PORTS-1:0] multicast_symbol_event,
  input wire logic logical_error,
  input wire logic [mss_pkg::NUM_PORTS-1:0] multicast_latency_timeout,
  input wire logic multicast_packet_dropped,
  input wire logic [mss_pkg::NUM_PORTS-1:0] port_irq,
  // alert
  input wire logic [mss_pkg::DATA_W-1:0] alert_enable,
  input wire logic alert_ack,
  output logic alert_flag,
  // logical error capture is free
  output logic logical_error_ready
);

  ////////////////////////////////////////////////////////////////////
  // decode and per-bit controls

  logic [mss_pkg::DATA_W-1:0] status; // the register itself
  logic [mss_pkg::DATA_W-1:0] set_vec; // hardware set per bit
  logic [mss_pkg::DATA_W-1:0] clr_vec; // external clear per bit
  logic [mss_pkg::DATA_W-1:0] load_vec; // software load per bit
  logic wr_hit; // register bus write to this word
  logic rd_hit; // register bus read of this word

  // address match on the internal register bus
  always_comb begin
    wr_hit = reg_wr_en && (reg_addr == mss_pkg::STAT_OFFSET);
    rd_hit = reg_rd_en && (reg_addr == mss_pkg::STAT_OFFSET);
  end

  // software reaches only the three soft flags
  always_comb begin
    load_vec = mss_pkg::SOFT_MASK & {mss_pkg::DATA_W{wr_hit}};
  end

  // clears come only from the serial side, one per written 1
  always_comb begin
    clr_vec = mgmt_w1c_data & {mss_pkg::DATA_W{mgmt_w1c_en}};
  end

  // event sources mapped onto their positions
  always_comb begin
    set_vec = '0;
    set_vec[mss_pkg::POS_OUTBOUND_MAILBOX_WRITTEN] = outbound_mailbox_write;
    // a read of an empty mailbox is not an event
    set_vec[mss_pkg::POS_INBOUND_MAILBOX_READ] =
      inbound_mailbox_rd & inbound_mailbox_full;
    set_vec[mss_pkg::POS_MGMT_IRQ] = mgmt_irq;
    set_vec[mss_pkg::POS_FABRIC_TRANSFER_ERROR] = |fabric_transfer_error;
    set_vec[mss_pkg::POS_RESET_SYMBOL_EVENT] = |reset_symbol_event;
    set_vec[mss_pkg::POS_MULTICAST_SYMBOL_EVENT] = |multicast_symbol_event;
    // the bit itself is the single capture slot
    set_vec[mss_pkg::POS_LOGICAL_ERROR] = logical_error;
    set_vec[mss_pkg::POS_MULTICAST_LATENCY_TIMEOUT] =
      |multicast_latency_timeout;
    set_vec[mss_pkg::POS_MULTICAST_PACKET_DROPPED] = multicast_packet_dropped;
    // ports in reverse: bit 16 is the last port
    for (int i = 0; i < mss_pkg::NUM_PORTS; i++) begin
      set_vec[mss_pkg::POS_PORT_BASE + i] = port_irq[mss_pkg::NUM_PORTS-1-i];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // storage cells

  // reserved positions get no flop at all and read zero
  generate
    for (genvar b = 0; b < mss_pkg::DATA_W; b++) begin : g_bit
      if (mss_pkg::IMPL_MASK[b]) begin : g_cell
        mss_sticky_bit #(
          .RESET_VAL(mss_pkg::STAT_HW_RESET[b])
        ) u_bit (
          .ref_clk(ref_clk),
          .rst(rst),
          .ce(ce),
          .soft_clr(mgmt_soft_rst),
          .set(set_vec[b]),
          .clr(clr_vec[b]),
          .load(load_vec[b]),
          .load_val(reg_wdata[b]),
          .q(status[b])
        );
      end else begin : g_rsvd
        assign status[b] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // read paths

  logic [mss_pkg::DATA_W-1:0] next_reg_rdata;
  logic next_reg_rvalid;

  // read data captured on a hit, held otherwise
  always_comb begin
    next_reg_rdata = rd_hit ? status : reg_rdata;
    next_reg_rvalid = rd_hit;
  end

  // read response registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= mss_pkg::STAT_RESET;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // serial side sees the live flops, no extra latency
  assign mgmt_status = status;

  // upstream must hold a second logical error until this rises
  assign logical_error_ready = ~status[mss_pkg::POS_LOGICAL_ERROR];

  ////////////////////////////////////////////////////////////////////
  // alert

  mss_alert_detect u_alert (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .status(status),
    .alert_enable(alert_enable),
    .alert_ack(alert_ack),
    .alert_flag(alert_flag)
  );

  ////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic quiet; // enabled cycle with no soft reset
  assign quiet = ce && !mgmt_soft_rst;

  property p_soft_reset_clears;
    ce && mgmt_soft_rst |=> status == '0;
  endproperty
  a_soft_reset_clears: assert property (p_soft_reset_clears)
    else $error("soft reset left status bits set");

  property p_soft_write;
    quiet && wr_hit |=> status[3:1] == $past(reg_wdata[3:1]);
  endproperty
  a_soft_write: assert property (p_soft_write)
    else $error("soft flags differ from written value");

  property p_soft_hold;
    quiet && !wr_hit && !(mgmt_w1c_en && |mgmt_w1c_data[3:1])
      |=> $stable(status[3:1]);
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("soft flags changed without a write");

  property p_outbound;
    quiet && outbound_mailbox_write |=> status[4];
  endproperty
  a_outbound: assert property (p_outbound)
    else $error("outbound mailbox write not recorded");

  property p_inbound_empty;
    quiet && inbound_mailbox_rd && !inbound_mailbox_full && !status[5]
      |=> !status[5];
  endproperty
  a_inbound_empty: assert property (p_inbound_empty)
    else $error("empty mailbox read raised the read bit");

  property p_inbound;
    quiet && inbound_mailbox_rd && inbound_mailbox_full |=> status[5];
  endproperty
  a_inbound: assert property (p_inbound)
    else $error("full mailbox read not recorded");

  property p_sources;
    quiet |=> (status[6] || !$past(mgmt_irq))
      && (status[8] || !$past(|reset_symbol_event))
      && (status[9] || !$past(|multicast_symbol_event))
      && (status[14] || !$past(|multicast_latency_timeout))
      && (status[15] || !$past(multicast_packet_dropped));
  endproperty
  a_sources: assert property (p_sources)
    else $error("level source not captured");

  property p_fabric;
    quiet && |fabric_transfer_error |=> status[7];
  endproperty
  a_fabric: assert property (p_fabric)
    else $error("fabric transfer error not captured");

  property p_logical;
    quiet && logical_error |=> status[13] && !logical_error_ready;
  endproperty
  a_logical: assert property (p_logical)
    else $error("logical error not captured or slot still free");

  property p_port_order;
    quiet && port_irq[0] && !port_irq[15] && !status[16] |=> status[31] && !status[16];
  endproperty
  a_port_order: assert property (p_port_order)
    else $error("port interrupt landed on the wrong bit");

  property p_reserved;
    status[12:10] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_sticky;
    quiet && status[7] && !(mgmt_w1c_en && mgmt_w1c_data[7]) |=> status[7];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit dropped without a clear");

  property p_w1c;
    quiet && status[7] && mgmt_w1c_en && mgmt_w1c_data[7]
      && !(|fabric_transfer_error) |=> !status[7];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one to clear did not clear");

  // any source active under a clear must leave its bit set
  property p_set_beats_clear;
    quiet && mgmt_w1c_en && |(mgmt_w1c_data & set_vec)
      |=> (status & $past(set_vec)) == $past(set_vec);
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("active source lost to clear");

  property p_write_beats_clear;
    quiet && wr_hit && mgmt_w1c_en && mgmt_w1c_data[2] && reg_wdata[2] |=> status[2];
  endproperty
  a_write_beats_clear: assert property (p_write_beats_clear)
    else $error("clear overrode software write");

  c_write_vs_clear: cover property (quiet && wr_hit && mgmt_w1c_en && mgmt_w1c_data[2]);
  c_set_vs_clear: cover property (quiet && mgmt_w1c_en && mgmt_w1c_data[6]
    && mgmt_irq);
  c_soft_reset: cover property (ce && mgmt_soft_rst ##1 status == '0);
  c_read: cover property (quiet && rd_hit ##1 reg_rvalid);

endmodule : mss_status_reg

`default_nettype wire

// file: verification/mss_mgmt_master.sv
// behavioural external management master issuing serial write-one-to-clear words
`timescale 1ns/10ps
`default_nettype none

module mss_mgmt_master (
  // clock
  input wire logic ref_clk,
  // serial slave side of the status register
  output logic mgmt_w1c_en,
  output logic [mss_pkg::DATA_W-1:0] mgmt_w1c_data
);
  // idle bus shows the inverse of the last word, never a stale copy
  initial begin
    mgmt_w1c_en = 1'b0;
    mgmt_w1c_data = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one clear word: strobe for exactly one taking edge
  task automatic w1c(input logic [mss_pkg::DATA_W-1:0] d);
    @(posedge ref_clk);
    mgmt_w1c_en <= 1'b1;
    mgmt_w1c_data <= d;
    @(posedge ref_clk);
    mgmt_w1c_en <= 1'b0;
    mgmt_w1c_data <= ~d;
  endtask : w1c
endmodule : mss_mgmt_master

`default_nettype wire

// file: verification/mgmt_summary_status_reg_tb_top.sv
// self-checking bench for the summary status register
`timescale 1ns/10ps
`default_nettype none

module mgmt_summary_status_reg_tb_top;
  // clock and resets
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic mgmt_soft_rst = 1'b0;
  // register bus
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [mss_pkg::ADDR_W-1:0] reg_addr = 20'h00000;
  logic [mss_pkg::DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic [mss_pkg::DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  // serial side
  logic mgmt_w1c_en;
  logic [mss_pkg::DATA_W-1:0] mgmt_w1c_data;
  logic [mss_pkg::DATA_W-1:0] mgmt_status;
  // event stimulus: one bit per status position
  logic [31:0] ev = 32'h0000_0000;
  logic [31:0] evm; // one-hot event of the current loop pass
  logic [15:0] port_ev; // ev[31:16] in port order: port 0 is bit 31
  logic mb_full = 1'b0;
  // alert
  logic [31:0] alert_enable = 32'h0000_0000;
  logic alert_ack = 1'b0;
  logic alert_flag;
  logic logical_error_ready;
  // bookkeeping
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int evb[11] = '{4, 5, 6, 7, 8, 9, 13, 14, 15, 16, 31};

  always #2.5 ref_clk = ~ref_clk;

  // port p drives status bit 31-p, so the stimulus word is reversed here
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      port_ev[k] = ev[31-k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // design and far-side master
  mss_status_reg DUT (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .mgmt_soft_rst(mgmt_soft_rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mgmt_w1c_en(mgmt_w1c_en), .mgmt_w1c_data(mgmt_w1c_data),
    .mgmt_status(mgmt_status), .outbound_mailbox_write(ev[4]),
    .inbound_mailbox_rd(ev[5]), .inbound_mailbox_full(mb_full), .mgmt_irq(ev[6]),
    .fabric_transfer_error(ev[7] ? 16'h0200 : 16'h0000),
    .reset_symbol_event(ev[8] ? 16'h8000 : 16'h0000),
    .multicast_symbol_event(ev[9] ? 16'h0001 : 16'h0000),
    .logical_error(ev[13]),
    .multicast_latency_timeout(ev[14] ? 16'h0010 : 16'h0000),
    .multicast_packet_dropped(ev[15]), .port_irq(port_ev),
    .alert_enable(alert_enable), .alert_ack(alert_ack), .alert_flag(alert_flag),
    .logical_error_ready(logical_error_ready)
  );

  mss_mgmt_master u_master (
    .ref_clk(ref_clk), .mgmt_w1c_en(mgmt_w1c_en), .mgmt_w1c_data(mgmt_w1c_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles, verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : reg_wr

  // read and compare; a miss must give no answer
  task automatic reg_rd(input logic [19:0] a, input logic v, input logic [31:0] d);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    check({31'h0, reg_rvalid}, {31'h0, v});
    if (v) check(reg_rdata, d);
  endtask : reg_rd

  // one-cycle event pulse, checked after the taking edge
  task automatic pulse(input logic [31:0] e);
    @(posedge ref_clk);
    ev <= e;
    @(posedge ref_clk);
    ev <= 32'h0000_0000;
    #1;
  endtask : pulse

  task automatic clr(input logic [31:0] d);
    u_master.w1c(d);
    #1;
  endtask : clr

  task automatic summarize;
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // hang guard, well above the roughly 130 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check(mgmt_status, 32'h0000_0001);
    reg_rd(mss_pkg::STAT_OFFSET, 1'b1, 32'h0000_0001);
    // bit 0 ignores serial-free register writes, then soft reset clears it
    reg_wr(mss_pkg::STAT_OFFSET, 32'h0000_0000);
    check(mgmt_status, 32'h0000_0001);
    @(posedge ref_clk);
    mgmt_soft_rst <= 1'b1;
    @(posedge ref_clk);
    mgmt_soft_rst <= 1'b0;
    #1;
    check(mgmt_status, 32'h0000_0000);
    // soft flags: all-ones write reaches only bits 3:1
    reg_wr(mss_pkg::STAT_OFFSET, 32'hFFFF_FFFF);
    check(mgmt_status, 32'h0000_000E);
    reg_wr(mss_pkg::STAT_OFFSET, 32'h0000_000A);
    reg_rd(mss_pkg::STAT_OFFSET, 1'b1, 32'h0000_000A);
    reg_wr(mss_pkg::STAT_OFFSET + 20'h00004, 32'h0000_0004);
    reg_rd(mss_pkg::STAT_OFFSET + 20'h00004, 1'b0, 32'h0000_0000);
    check(mgmt_status, 32'h0000_000A);
    // software write meets serial clear in the same cycle
    fork
      reg_wr(mss_pkg::STAT_OFFSET, 32'h0000_0004);
      u_master.w1c(32'h0000_000E);
    join
    #1;
    check(mgmt_status, 32'h0000_0004);
    clr(32'h0000_0004);
    check(mgmt_status, 32'h0000_0000);
    // inbound read of an empty mailbox records nothing
    pulse(32'h0000_0020);
    check(mgmt_status, 32'h0000_0000);
    mb_full <= 1'b1;
    // every non-port source, plus ports 0 and 15, sets exactly its own bit and stays until cleared
    foreach (evb[i]) begin
      evm = 32'h1 << evb[i];
      pulse(evm);
      repeat (2) @(posedge ref_clk);
      #1;
      check(mgmt_status, evm);
      clr(evm);
      check(mgmt_status, 32'h0000_0000);
    end
    // held source survives a clear
    @(posedge ref_clk);
    ev <= 32'h0000_0040;
    clr(32'h0000_0040);
    check(mgmt_status, 32'h0000_0040);
    ev <= 32'h0000_0000;
    clr(32'h0000_0040);
    check(mgmt_status, 32'h0000_0000);
    // single logical error capture
    pulse(32'h0000_2000);
    check({31'h0, logical_error_ready}, 32'h0);
    pulse(32'h0000_2000);
    check(mgmt_status, 32'h0000_2000);
    clr(32'h0000_2000);
    check({31'h0, logical_error_ready}, 32'h1);
    // masked event raises no alert, enabled one does, ack drops it
    pulse(32'h0000_0080);
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, alert_flag}, 32'h0);
    clr(32'h0000_0080);
    alert_enable <= 32'h0000_0010;
    pulse(32'h0000_0010);
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, alert_flag}, 32'h1);
    @(posedge ref_clk);
    alert_ack <= 1'b1;
    @(posedge ref_clk);
    alert_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({31'h0, alert_flag}, 32'h0);
    check(mgmt_status, 32'h0000_0010);
    // enable low freezes the register: a dropped-packet pulse is not taken
    ce <= 1'b0;
    pulse(32'h0000_8000);
    check(mgmt_status, 32'h0000_0010);
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(mgmt_status, 32'h0000_0010);
    summarize();
  end
endmodule : mgmt_summary_status_reg_tb_top

`default_nettype wire
